// ### common/hpi_pkg.sv
package hpi_pkg;
    // ****************************************
    // Status byte layout
    // ****************************************
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_IRQ_BIT = 1;
    localparam int ST_READY_BIT = 3;
    localparam logic [7:0] ST_RESET = 8'h00;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 200;
    localparam int SELFTEST_LIMIT_MS = 2000;
    localparam longint SELFTEST_LIMIT_CYC = longint'(SELFTEST_LIMIT_MS) * 1000 * CLK_MHZ;
    // ****************************************
    // Host interrupt kinds
    // ****************************************
    localparam logic [1:0] IRQ_KIND_LINE = 2'h0;
    localparam logic [1:0] IRQ_KIND_IO = 2'h1;
    localparam logic [1:0] IRQ_KIND_MEM = 2'h2;
    // ****************************************
    // Configuration
    // ****************************************
    localparam logic [7:0] DONE_PENDING = 8'hff;
    localparam logic [7:0] DONE_OK = 8'h00;
    localparam logic [7:0] ERR_BAD_MODE = 8'ha4;
    localparam logic [7:0] ERR_BAD_PATTERN = 8'ha5;
    localparam logic [1:0] MODE_LINK = 2'h0;
    localparam logic [1:0] MODE_HOSTED = 2'h1;
    localparam logic [1:0] MODE_NETBOOT = 2'h2;
    localparam logic [31:0] PAT_LONG = 32'h0103070f;
    localparam logic [15:0] PAT_WORD0 = 16'h0103;
    localparam logic [31:0] PAT_BYTES = 32'h0f070301;
    localparam logic [31:0] START_SEQ = 32'h0000ffff;
    localparam int ADDR_W = 24;
    localparam int IO_ADDR_W = 16;
    localparam logic [2:0] CMD_BYTES = 3'h7;

    typedef enum logic [4:0] {
        HPI_TEST = 5'b00001,
        HPI_WAIT_CFG = 5'b00010,
        HPI_CHECK = 5'b00100,
        HPI_RUN = 5'b01000,
        HPI_FAIL = 5'b10000
    } hpi_state_t;
endpackage

// ### core/hpi_host_port.sv
`timescale 1ns/10ps
// Operation
// - Reading reset port resets the device
// - Fault bit clear on reset, set on pass
// - Passing self test sets bit within 2s
// - Fault bit zero signals fatal error
// - Interrupt bit follows level bus interrupt
// - Reset port write clears interrupt bit
// - Ready bit set while command byte unread
// - Reset port write releases interrupt line
// - Command write interrupts CPU with byte
// - Both ports read/write at jumper addresses
// - Master reaches 16M memory, 64K I/O
// - On-board memory never answers host
// - Host interrupt kind chosen at init
// - No I/O cycles unless I/O interrupts
// - Derive conversions from test pattern
// - Byte conversion inverts address bit zero
// - Word swap; longword half/byte swaps
// - Unmatched pattern aborts with error code
// - Failure shows code until reset again
// - Valid config enters one of three modes
// - Completion code written, zero is success
module hpi_host_port
    import hpi_pkg::*;
#(
    parameter longint SELFTEST_CYC = SELFTEST_LIMIT_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host I/O ports
    input wire logic [IO_ADDR_W-1:0] host_io_addr,
    input wire logic host_io_rd,
    input wire logic host_io_wr,
    input wire logic [7:0] host_io_wdata,
    output logic [7:0] host_io_rdata,
    output logic host_io_hit,
    input wire logic [IO_ADDR_W-1:0] jumper_reset_port,
    input wire logic [IO_ADDR_W-1:0] jumper_cmd_port,
    output logic board_reset,
    // On-board CPU side
    input wire logic selftest_pass,
    input wire logic selftest_fail,
    output logic cpu_cmd_irq,
    output logic [7:0] cpu_cmd_byte,
    input wire logic cpu_cmd_ack,
    input wire logic cpu_host_irq_req,
    input wire logic [1:0] cpu_irq_kind,
    input wire logic cfg_load,
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_convert_en,
    input wire logic [31:0] cfg_pat_bytes,
    input wire logic [15:0] cfg_pat_word,
    input wire logic [31:0] cfg_pat_long,
    input wire logic [ADDR_W-1:0] irq_mem_addr,
    input wire logic [IO_ADDR_W-1:0] irq_io_addr,
    // Bus master side
    input wire logic [ADDR_W-1:0] mst_addr_in,
    output logic [ADDR_W-1:0] mst_addr,
    output logic mst_io_wr,
    output logic mst_mem_wr,
    output logic [ADDR_W-1:0] mst_irq_addr,
    output logic bus_irq_line,
    // Conversion and status
    output logic conv_byte_flip,
    output logic conv_word_swap,
    output logic conv_half_swap,
    output logic conv_byte_swap,
    output logic [1:0] run_mode,
    output logic [7:0] done_code,
    output logic [7:0] error_display
);
    // ****************************************
    // Port decode
    // ****************************************
    logic hit_rst, hit_cmd;
    assign hit_rst = host_io_addr == jumper_reset_port;
    assign hit_cmd = host_io_addr == jumper_cmd_port;
    // Only the two ports answer; on-board memory is never exposed
    assign host_io_hit = (hit_rst || hit_cmd) && (host_io_rd || host_io_wr);
    assign board_reset = host_io_rd && hit_rst;

    // ****************************************
    // Order helpers
    // ****************************************
    // Pairs of bytes trade places, as a flipped address bit 0 makes them
    function automatic logic [31:0] swap_in_halves(input logic [31:0] v);
        return {v[23:16], v[31:24], v[7:0], v[15:8]};
    endfunction
    // The two halfwords trade places
    function automatic logic [31:0] swap_halves(input logic [31:0] v);
        return {v[15:0], v[31:16]};
    endfunction
    // The two bytes of a word trade places
    function automatic logic [15:0] swap_word(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction

    // ****************************************
    // State
    // ****************************************
    hpi_state_t state_reg, state_next;
    logic fault_ok_reg, fault_ok_next;
    logic irq_reg, irq_next;
    logic ready_reg, ready_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [63:0] seq_reg, seq_next;
    logic [2:0] cnt_reg, cnt_next;
    longint tmr_reg, tmr_next;
    logic [3:0] conv_reg, conv_next;
    logic [1:0] mode_reg, mode_next;
    logic [7:0] code_reg, code_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [1:0] kind_reg, kind_next;
    logic mio_reg, mio_next, mmem_reg, mmem_next;

    logic do_reset;
    assign do_reset = rst || board_reset;

    always_comb begin
        state_next = state_reg;
        fault_ok_next = fault_ok_reg;
        irq_next = irq_reg;
        ready_next = ready_reg;
        cmd_next = cmd_reg;
        seq_next = seq_reg;
        cnt_next = cnt_reg;
        tmr_next = tmr_reg;
        conv_next = conv_reg;
        mode_next = mode_reg;
        code_next = code_reg;
        kind_next = kind_reg;
        mio_next = 1'b0;
        mmem_next = 1'b0;
        rdata_next = rdata_reg;

        // ****************************************
        // Status snapshot
        // ****************************************
        // Unused status bits read as zero so a host mask never sees noise
        if (host_io_rd && hit_cmd) begin
            rdata_next = 8'h00;
            rdata_next[ST_FAULT_BIT] = fault_ok_reg;
            rdata_next[ST_IRQ_BIT] = irq_reg;
            rdata_next[ST_READY_BIT] = ready_reg;
        end

        // ****************************************
        // Host interrupt
        // ****************************************
        // Set wins over a concurrent clear, so a fresh request is never lost
        if (host_io_wr && hit_rst) begin
            irq_next = 1'b0;
        end
        if (cpu_host_irq_req) begin
            case (kind_reg)
                IRQ_KIND_LINE: irq_next = 1'b1;
                IRQ_KIND_IO: mio_next = 1'b1;
                IRQ_KIND_MEM: mmem_next = 1'b1;
                default: irq_next = irq_reg;
            endcase
        end

        // ****************************************
        // Command byte mailbox
        // ****************************************
        // A write in the cycle of an acknowledge wins: that byte is still unread
        if (cpu_cmd_ack) begin
            ready_next = 1'b0;
        end
        if (host_io_wr && hit_cmd) begin
            cmd_next = host_io_wdata;
            ready_next = 1'b1;
        end

        // ****************************************
        // Initialisation sequencer
        // ****************************************
        case (state_reg)
            HPI_TEST: begin
                tmr_next = tmr_reg + 1;
                if (selftest_pass) begin
                    fault_ok_next = 1'b1;
                    state_next = HPI_WAIT_CFG;
                end else if (selftest_fail || tmr_reg >= SELFTEST_CYC) begin
                    // A hung self test also fails, so the board never sits silent
                    code_next = 8'h01;
                    state_next = HPI_FAIL;
                end
            end
            HPI_WAIT_CFG: begin
                if (host_io_wr && hit_cmd) begin
                    // Address bytes arrive least significant first
                    seq_next = {host_io_wdata, seq_reg[63:8]};
                    cnt_next = cnt_reg + 3'h1;
                end
                if (cfg_load) begin
                    kind_next = cpu_irq_kind;
                    state_next = HPI_CHECK;
                end
            end
            HPI_CHECK: begin
                conv_next = 4'h0;
                code_next = DONE_OK;
                if (cfg_convert_en) begin
                    // Byte array: native lanes, or lanes paired by a flipped address bit 0
                    if (cfg_pat_bytes == PAT_BYTES) conv_next[0] = 1'b0;
                    else if (swap_in_halves(cfg_pat_bytes) == PAT_BYTES) conv_next[0] = 1'b1;
                    else code_next = ERR_BAD_PATTERN;
                    if (cfg_pat_word == PAT_WORD0) conv_next[1] = 1'b0;
                    else if (swap_word(cfg_pat_word) == PAT_WORD0) conv_next[1] = 1'b1;
                    else code_next = ERR_BAD_PATTERN;
                    if (cfg_pat_long == PAT_LONG) conv_next[3:2] = 2'h0;
                    else if (swap_halves(cfg_pat_long) == PAT_LONG) conv_next[3:2] = 2'h1;
                    else if (swap_in_halves(cfg_pat_long) == PAT_LONG) conv_next[3:2] = 2'h2;
                    else if (swap_halves(swap_in_halves(cfg_pat_long)) == PAT_LONG) conv_next[3:2] = 2'h3;
                    else code_next = ERR_BAD_PATTERN;
                end
                if (cfg_mode != MODE_LINK && cfg_mode != MODE_HOSTED && cfg_mode != MODE_NETBOOT) begin
                    code_next = ERR_BAD_MODE;
                end
                mode_next = cfg_mode;
                state_next = HPI_RUN;
                // A short or malformed start sequence leaves the message address untrusted
                if (seq_reg[31:0] != START_SEQ || cnt_reg != 3'h0) code_next = ERR_BAD_PATTERN;
            end
            HPI_RUN: begin
                if (code_reg != DONE_OK) state_next = HPI_FAIL;
            end
            HPI_FAIL: state_next = HPI_FAIL;
            default: state_next = HPI_TEST;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (do_reset) begin
            state_reg <= HPI_TEST;
            fault_ok_reg <= 1'b0;
            irq_reg <= 1'b0;
            ready_reg <= 1'b0;
            cmd_reg <= 8'h00;
            seq_reg <= 64'h0;
            cnt_reg <= 3'h0;
            tmr_reg <= 0;
            conv_reg <= 4'h0;
            mode_reg <= MODE_LINK;
            code_reg <= DONE_PENDING;
            rdata_reg <= ST_RESET;
            kind_reg <= IRQ_KIND_LINE;
            mio_reg <= 1'b0;
            mmem_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fault_ok_reg <= fault_ok_next;
            irq_reg <= irq_next;
            ready_reg <= ready_next;
            cmd_reg <= cmd_next;
            seq_reg <= seq_next;
            cnt_reg <= cnt_next;
            tmr_reg <= tmr_next;
            conv_reg <= conv_next;
            mode_reg <= mode_next;
            code_reg <= code_next;
            rdata_reg <= rdata_next;
            kind_reg <= kind_next;
            mio_reg <= mio_next;
            mmem_reg <= mmem_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign host_io_rdata = rdata_reg;
    assign cpu_cmd_irq = ready_reg;
    assign cpu_cmd_byte = cmd_reg;
    assign bus_irq_line = irq_reg;

    // ****************************************
    // Bus master
    // ****************************************
    assign mst_io_wr = mio_reg;
    assign mst_mem_wr = mmem_reg;
    assign mst_irq_addr = (kind_reg == IRQ_KIND_IO) ? {{(ADDR_W-IO_ADDR_W){1'b0}}, irq_io_addr} : irq_mem_addr;
    // Full 24-bit reach; bit 0 flipped for swapped-lane hosts
    assign mst_addr = {mst_addr_in[ADDR_W-1:1], mst_addr_in[0] ^ conv_reg[0]};

    // ****************************************
    // Conversion and status
    // ****************************************
    // Longword code: bit 2 trades halfwords, bit 3 trades bytes within them
    assign conv_byte_flip = conv_reg[0];
    assign conv_word_swap = conv_reg[1];
    assign conv_half_swap = conv_reg[2];
    assign conv_byte_swap = conv_reg[3];
    assign run_mode = mode_reg;
    assign done_code = code_reg;
    assign error_display = (state_reg == HPI_FAIL) ? code_reg : 8'h00;
endmodule // hpi_host_port

// ### verif/hpi_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host processor on the shared bus
// ****************************************
module hpi_host_model
    import hpi_pkg::*;
(
    // Clock and status
    input wire logic core_clk,
    input wire logic [7:0] host_io_rdata,
    // Host I/O cycle
    output logic [IO_ADDR_W-1:0] host_io_addr,
    output logic host_io_rd,
    output logic host_io_wr,
    output logic [7:0] host_io_wdata
);
    initial begin
        {host_io_addr, host_io_rd, host_io_wr, host_io_wdata} = '0;
    end
    // One cycle of strobe; strobes then drop low while address and data show their inverse so stale values never pass
    task automatic acc(input logic [IO_ADDR_W-1:0] a, input logic rd, input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        #1 {host_io_addr, host_io_rd, host_io_wr, host_io_wdata} = {a, rd, !rd, d};
        @(posedge core_clk);
        #1 {host_io_addr, host_io_rd, host_io_wr, host_io_wdata} = {~a, 2'b00, ~d};
        q = host_io_rdata;
    endtask
    // Start sequence then message address, each byte once ready is clear
    task automatic send_cfg(input logic [IO_ADDR_W-1:0] port, input logic [31:0] addr);
        logic [63:0] seq = {addr, START_SEQ};
        logic [7:0] st;
        for (int i = 0; i < 8; i++) begin
            st = 8'hff;
            for (int j = 0; j < 20 && st[ST_READY_BIT] !== 1'b0; j++) begin
                acc(port, 1'b1, 8'h00, st);
            end
            acc(port, 1'b0, seq[8*i+:8], st);
        end
    endtask
endmodule // hpi_host_model

// ### verif/hpi_host_port_assertions.sv
`timescale 1ns/10ps
// ****************************************
// Host port checker
// ****************************************
module hpi_host_port_chk
    import hpi_pkg::*;
#(
    parameter longint SELFTEST_CYC = 100
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host ports
    input wire logic [IO_ADDR_W-1:0] host_io_addr,
    input wire logic host_io_rd,
    input wire logic host_io_wr,
    input wire logic [7:0] host_io_rdata,
    input wire logic host_io_hit,
    input wire logic [IO_ADDR_W-1:0] jumper_reset_port,
    input wire logic [IO_ADDR_W-1:0] jumper_cmd_port,
    input wire logic board_reset,
    // Board side
    input wire logic selftest_pass,
    input wire logic cpu_cmd_irq,
    input wire logic cpu_cmd_ack,
    input wire logic cpu_host_irq_req,
    input wire logic bus_irq_line
);
    logic pass_seen_reg, pass_seen_next;
    wire logic rd_rst = host_io_rd && host_io_addr == jumper_reset_port;
    wire logic wr_rst = host_io_wr && host_io_addr == jumper_reset_port;
    wire logic rd_cmd = host_io_rd && host_io_addr == jumper_cmd_port;
    wire logic wr_cmd = host_io_wr && host_io_addr == jumper_cmd_port;
    // Only a pass seen since the last reset of either kind may set the fault bit
    always_comb begin
        pass_seen_next = (pass_seen_reg || selftest_pass) && !rst && !board_reset;
    end
    always_ff @(posedge core_clk) begin
        pass_seen_reg <= pass_seen_next;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    property p_rd_reset; rd_rst |-> board_reset && host_io_hit; endproperty
    a_rd_reset: assert property (p_rd_reset) else $error("reset port read did not reset");
    property p_fault_low; rd_cmd && !selftest_pass && !pass_seen_reg |=> !host_io_rdata[ST_FAULT_BIT]; endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault bit set without pass");
    property p_ready_set; wr_cmd && !cpu_cmd_ack |=> cpu_cmd_irq; endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set by command write");
    property p_ready_clear; cpu_cmd_ack && !wr_cmd |=> !cpu_cmd_irq; endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared by ack");
    property p_status; rd_cmd |=> host_io_rdata[ST_READY_BIT] == $past(cpu_cmd_irq) && host_io_rdata[7:4] == 4'h0; endproperty
    a_status: assert property (p_status) else $error("status byte wrong");
    property p_irq_bit; rd_cmd && bus_irq_line |=> host_io_rdata[ST_IRQ_BIT]; endproperty
    a_irq_bit: assert property (p_irq_bit) else $error("interrupt bit clear while line set");
    property p_irq_drop; wr_rst && !cpu_host_irq_req |=> !bus_irq_line ##1 (!bus_irq_line || $past(cpu_host_irq_req)); endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("interrupt line not released");
    property p_irq_cause; $rose(bus_irq_line) |-> $past(cpu_host_irq_req); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt line rose unasked");
    property p_unmapped; (host_io_rd || host_io_wr) && host_io_addr != jumper_reset_port
        && host_io_addr != jumper_cmd_port |-> !host_io_hit && !board_reset; endproperty
    a_unmapped: assert property (p_unmapped) else $error("foreign address answered");
endmodule // hpi_host_port_chk
bind hpi_host_port hpi_host_port_chk #(.SELFTEST_CYC(SELFTEST_CYC)) u_chk (.core_clk, .rst, .host_io_addr, .host_io_rd,
    .host_io_wr, .host_io_rdata, .host_io_hit, .jumper_reset_port, .jumper_cmd_port, .board_reset, .selftest_pass,
    .cpu_cmd_irq, .cpu_cmd_ack, .cpu_host_irq_req, .bus_irq_line);

// ### verif/hpi_host_port_tb.sv
`timescale 1ns/10ps
// ****************************************
// Host port bench
// ****************************************
module hpi_host_port_tb;
    import hpi_pkg::*;
    localparam logic [15:0] RST_PORT = 16'h0300, CMD_PORT = 16'h0304;
    logic core_clk = 1'b0, rst = 1'b1, selftest_pass = 1'b0, selftest_fail = 1'b0, cpu_cmd_ack = 1'b0;
    logic cpu_host_irq_req = 1'b0, cfg_load = 1'b0, cfg_convert_en = 1'b0, host_io_rd, host_io_wr, host_io_hit;
    logic board_reset, cpu_cmd_irq, mst_io_wr, mst_mem_wr, bus_irq_line;
    logic conv_byte_flip, conv_word_swap, conv_half_swap, conv_byte_swap;
    logic [1:0] cpu_irq_kind = 2'h0, cfg_mode = 2'h0, run_mode;
    logic [7:0] host_io_wdata, host_io_rdata, cpu_cmd_byte, done_code, error_display, st, exp_q[$];
    logic [15:0] host_io_addr, irq_io_addr = 16'h0, jumper_reset_port = RST_PORT, jumper_cmd_port = CMD_PORT;
    logic [15:0] cfg_pat_word = 16'h0;
    logic [31:0] cfg_pat_bytes = 32'h0, cfg_pat_long = 32'h0;
    logic [23:0] irq_mem_addr = 24'h0, mst_addr_in = 24'h0, mst_addr, mst_irq_addr;
    integer seed = 28, err_total = 0, total_checks = 0;
    always #2.5 core_clk = ~core_clk;
    hpi_host_port #(.SELFTEST_CYC(100)) uut (.core_clk, .rst, .host_io_addr, .host_io_rd, .host_io_wr, .host_io_wdata,
        .host_io_rdata, .host_io_hit, .jumper_reset_port, .jumper_cmd_port, .board_reset, .selftest_pass,
        .selftest_fail, .cpu_cmd_irq, .cpu_cmd_byte, .cpu_cmd_ack, .cpu_host_irq_req, .cpu_irq_kind, .cfg_load,
        .cfg_mode, .cfg_convert_en, .cfg_pat_bytes, .cfg_pat_word, .cfg_pat_long, .irq_mem_addr, .irq_io_addr,
        .mst_addr_in, .mst_addr, .mst_io_wr, .mst_mem_wr, .mst_irq_addr, .bus_irq_line, .conv_byte_flip,
        .conv_word_swap, .conv_half_swap, .conv_byte_swap, .run_mode, .done_code, .error_display);
    hpi_host_model host (.core_clk, .host_io_rdata, .host_io_addr, .host_io_rd, .host_io_wr, .host_io_wdata);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t value %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(posedge core_clk);
        #1 s = 1'b1;
        @(posedge core_clk);
        #1 s = 1'b0;
    endtask
    // Reset, self test, start sequence, configuration, then one host interrupt when the expected code is zero
    task automatic boot(input logic [1:0] mode, input logic [1:0] kind, input logic [1:0] pat, input logic [7:0] code);
        logic [31:0] a = $random(seed) & 32'h00fffffe;
        host.acc(RST_PORT, 1'b1, 8'h00, st);
        check(done_code, DONE_PENDING);
        pulse(selftest_pass);
        st = 8'h00;
        for (int i = 0; i < 60 && st[ST_FAULT_BIT] !== 1'b1; i++) begin
            host.acc(CMD_PORT, 1'b1, 8'h00, st);
        end
        check(st[ST_FAULT_BIT], 1'b1);
        for (int i = 0; i < 8; i++) exp_q.push_back(i < 4 ? START_SEQ[8*i+:8] : a[8*i-32+:8]);
        host.send_cfg(CMD_PORT, a);
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge core_clk);
        #1 {cfg_mode, cpu_irq_kind, cfg_convert_en} = {mode, kind, pat != 2'h0};
        cfg_pat_bytes = pat == 2'h1 ? 32'h070f0103 : pat == 2'h2 ? 32'h0 : PAT_BYTES;
        cfg_pat_word = pat == 2'h1 ? 16'h0301 : pat == 2'h2 ? 16'h0 : PAT_WORD0;
        cfg_pat_long = pat == 2'h1 ? 32'h0f070301 : pat == 2'h2 ? 32'h0 : pat == 2'h3 ? 32'h03010f07 : PAT_LONG;
        pulse(cfg_load);
        for (int i = 0; i < 50 && done_code === DONE_PENDING; i++) @(posedge core_clk);
        #1 check(done_code, code);
        check(code != 8'h00 ? error_display : run_mode, code != 8'h00 ? code : mode);
        if (code == 8'h00) begin
            check({conv_byte_flip, conv_word_swap, conv_half_swap, conv_byte_swap},
                  {{3{pat == 2'h1}}, pat[0]});
            mst_addr_in = 24'($random(seed));
            irq_io_addr = 16'($random(seed));
            irq_mem_addr = 24'($random(seed));
            #1 check(mst_addr, mst_addr_in ^ {23'h0, pat == 2'h1});
            pulse(cpu_host_irq_req);
            check({bus_irq_line, mst_io_wr, mst_mem_wr}, 3'b100 >> kind);
            if (kind != 2'h0) check(mst_irq_addr, kind == 2'h1 ? irq_io_addr : irq_mem_addr);
            host.acc(CMD_PORT, 1'b1, 8'h00, st);
            check(st[ST_IRQ_BIT], kind == 2'h0);
            host.acc(RST_PORT, 1'b0, 8'($random(seed)), st);
            host.acc(CMD_PORT, 1'b1, 8'h00, st);
            check({bus_irq_line, st[ST_IRQ_BIT], st[ST_FAULT_BIT]}, 3'b001);
        end
    endtask
    // The board side takes each byte a cycle after it lands
    initial forever begin
        @(posedge core_clk);
        #1;
        if (cpu_cmd_irq === 1'b1) begin
            check(cpu_cmd_byte, exp_q.size() != 0 ? exp_q.pop_front() : 32'hffffffff);
            cpu_cmd_ack = 1'b1;
            @(posedge core_clk);
            #1 cpu_cmd_ack = 1'b0;
        end
    end
    // About ten times the expected run
    initial begin
        #(6000 * 5);
        err_total++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        host.acc(16'h0302, 1'b1, 8'h00, st);
        pulse(selftest_fail);
        host.acc(CMD_PORT, 1'b1, 8'h00, st);
        check({st[ST_FAULT_BIT], error_display}, 9'h001);
        host.acc(RST_PORT, 1'b1, 8'h00, st);
        repeat (105) @(posedge core_clk);
        host.acc(CMD_PORT, 1'b1, 8'h00, st);
        check({st[ST_FAULT_BIT], error_display}, 9'h001);
        for (int k = 0; k < 3; k++) boot(2'(k), 2'(k), 2'h0, DONE_OK);
        boot(2'h3, 2'h0, 2'h0, ERR_BAD_MODE);
        boot(2'h0, 2'h0, 2'h2, ERR_BAD_PATTERN);
        boot(2'h1, 2'h0, 2'h1, DONE_OK);
        boot(2'h2, 2'h1, 2'h3, DONE_OK);
        final_report();
    end
endmodule // hpi_host_port_tb
